// ---- hw/nacc_map.svh ----
// offsets, field values, reset values and limits of the node address block
`ifndef NACC_MAP_SVH
`define NACC_MAP_SVH
// ****************************************************************
// holding register offsets (16-bit registers)
// ****************************************************************
`define NACC_OFS_ADDR    16'h0139
`define NACC_OFS_BAUD    16'h013A
`define NACC_OFS_PARITY  16'h013B
`define NACC_OFS_PERSIST 16'h013D
`define NACC_OFS_ORDER   16'h080A
// ****************************************************************
// setting slots, shared by store, panel select and decode
// ****************************************************************
`define NACC_IX_ADDR     3'h0
`define NACC_IX_BAUD     3'h1
`define NACC_IX_PARITY   3'h2
`define NACC_IX_PERSIST  3'h3
`define NACC_IX_ORDER    3'h4
`define NACC_IX_COUNT    3'h5
// ****************************************************************
// enumerated codes and reset values
// ****************************************************************
`define NACC_BAUD_9600   16'h00BC
`define NACC_BAUD_19200  16'h00BD
`define NACC_BAUD_38400  16'h00BE
`define NACC_PAR_EVEN    16'h00BF
`define NACC_PAR_ODD     16'h00C0
`define NACC_PAR_NONE    16'h003D
`define NACC_ORD_LOHI    16'h0533
`define NACC_ORD_HILO    16'h0532
`define NACC_SAVE_YES    16'h006A
`define NACC_SAVE_NO     16'h003B
`define NACC_ADDR_RST    16'h00F7
// ****************************************************************
// address limits and switch fields
// ****************************************************************
`define NACC_ADDR_MIN    16'h0001
`define NACC_ADDR_MAX    16'h00F7
`define NACC_DIP_ALL     4'hF
`define NACC_DIP_PROTO   3
`endif

// ---- hw/nacc_pkg.sv ----
// types and shared decode functions of the node address block
package nacc_pkg;
  `include "nacc_map.svh"

  // start-up sequence: restore from store, resolve switches, serve
  typedef enum logic [1:0] {ST_LOAD, ST_RESOLVE, ST_RUN} nacc_state_t;

  // is a value legal for a given setting slot
  function automatic logic nacc_valid(input logic [2:0]  idx,
                                      input logic [15:0] d);
    case (idx)
      `NACC_IX_ADDR:    return (d >= `NACC_ADDR_MIN) && (d <= `NACC_ADDR_MAX);
      `NACC_IX_BAUD:    return (d == `NACC_BAUD_9600) ||
                               (d == `NACC_BAUD_19200) ||
                               (d == `NACC_BAUD_38400);
      `NACC_IX_PARITY:  return (d == `NACC_PAR_EVEN) ||
                               (d == `NACC_PAR_ODD) || (d == `NACC_PAR_NONE);
      `NACC_IX_PERSIST: return (d == `NACC_SAVE_YES) || (d == `NACC_SAVE_NO);
      `NACC_IX_ORDER:   return (d == `NACC_ORD_LOHI) || (d == `NACC_ORD_HILO);
      default:          return 1'b0;
    endcase
  endfunction

  // register offset to {hit, slot}
  function automatic logic [3:0] nacc_decode(input logic [15:0] a);
    case (a)
      `NACC_OFS_ADDR:    return {1'b1, `NACC_IX_ADDR};
      `NACC_OFS_BAUD:    return {1'b1, `NACC_IX_BAUD};
      `NACC_OFS_PARITY:  return {1'b1, `NACC_IX_PARITY};
      `NACC_OFS_PERSIST: return {1'b1, `NACC_IX_PERSIST};
      `NACC_OFS_ORDER:   return {1'b1, `NACC_IX_ORDER};
      default:           return 4'h0;
    endcase
  endfunction
endpackage

// ---- hw/nacc_sync.sv ----
// two-flop synchroniser for switch and strap pins
`timescale 1ns/1ns
module nacc_sync #(
  parameter int unsigned WIDTH = 5
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // pin side and clock side
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta;  // first stage, read by the second only

  // ****************************************************************
  // synchroniser stages
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync <= '0;
    end
    else
    begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule // nacc_sync

// ---- hw/nacc_nvstore.sv ----
// nonvolatile settings store model, registered read data
`timescale 1ns/1ns
module nacc_nvstore #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  // clock
  input  wire logic             clock,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  // no reset on purpose: contents survive a restart like the real store
  logic [WIDTH-1:0] mem [DEPTH];

  // ****************************************************************
  // write and registered read
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end
endmodule // nacc_nvstore

// ---- hw/nacc_top.sv ----
// node address selection and serial communication settings bank
`timescale 1ns/1ns
// Contract
// - modbus address 1-8 by switch, 1-247 by software
// - switch 4 on selects modbus, off vendor bus
// - vendor bus may write modbus address 1-247
// - software address applies only at 8 after restart
// - lower switch address beats software address
// - modbus units: vendor address switches 1-3 plus one
// - vendor-only units: four switches plus one, 1-16
// - modbus writes of settings take effect immediately
// - panel settings always saved to nonvolatile store
// - persist setting picks store for network writes
// - panel edits allowed only on firmware 3 up
// - 16-bit registers, word order selectable
module nacc_top
  import nacc_pkg::*;
#(
  parameter int unsigned FW_MAJOR = 3  // firmware major release
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // switch and option pins
  input  wire logic [3:0]  dip_sw,
  input  wire logic        modbus_fitted,
  // holding register port from the modbus frame handler
  input  wire logic        mb_wr,
  input  wire logic        mb_rd,
  input  wire logic [15:0] mb_addr,
  input  wire logic [15:0] mb_wdata,
  output logic             mb_ack,
  output logic             mb_fault,
  output logic      [15:0] mb_rdata,
  // address write from the vendor bus handler
  input  wire logic        vb_wr,
  input  wire logic [15:0] vb_wdata,
  output logic             vb_ack,
  // setup menu writes from the operator display unit
  input  wire logic        panel_wr,
  input  wire logic [2:0]  panel_sel,
  input  wire logic [15:0] panel_wdata,
  // resolved settings
  output logic             ready,
  output logic             use_modbus,
  output logic      [7:0]  modbus_address,
  output logic      [4:0]  vendor_address,
  output logic      [15:0] baud_code,
  output logic      [15:0] parity_code,
  output logic             word_swap,
  output logic             persist_network
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [3:0]  dip_s;                  // synchronised switches
  logic        fitted_s;               // synchronised option strap
  nacc_state_t state, next_state;      // start-up sequencer
  logic [2:0]  ld_idx, next_ld_idx;    // restore slot counter
  logic [15:0] cfg [5];                // live settings
  logic [15:0] next_cfg [5];
  logic [3:0]  dip_l, next_dip_l;      // switches taken at restart
  logic        fitted, next_fitted;    // option strap taken at restart
  logic        next_ready, next_use_modbus, next_word_swap;
  logic        next_persist, next_mb_ack, next_mb_fault, next_vb_ack;
  logic [7:0]  next_mb_address;
  logic [4:0]  next_vendor_address;
  logic [15:0] next_mb_rdata;
  logic        nv_we, nv_re;           // store strobes
  logic [2:0]  nv_waddr, nv_raddr;
  logic [15:0] nv_wdata, nv_rdata;
  logic [3:0]  mb_dec;                 // {hit, slot} of mb_addr
  logic        sw_all_on;              // switches were at 8 at restart
  logic        panel_ok, vb_ok, mb_ok; // accepted writes this cycle

  // ****************************************************************
  // pin synchronisers and settings store
  // ****************************************************************
  nacc_sync #(.WIDTH(5)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pin   ({modbus_fitted, dip_sw}),
    .sync  ({fitted_s, dip_s})
  );

  nacc_nvstore #(.WIDTH(16), .DEPTH(8), .AW(3)) u_store (
    .clock (clock),
    .we    (nv_we),
    .waddr (nv_waddr),
    .wdata (nv_wdata),
    .re    (nv_re),
    .raddr (nv_raddr),
    .rdata (nv_rdata)
  );

  // ****************************************************************
  // write qualification
  // ****************************************************************
  assign mb_dec    = nacc_decode(mb_addr);
  assign sw_all_on = fitted && (dip_l == `NACC_DIP_ALL);
  // modbus may always change its settings; illegal codes drop out
  assign mb_ok     = (state == ST_RUN) && mb_wr && mb_dec[3] &&
                     nacc_valid(mb_dec[2:0], mb_wdata);
  // menu edits exist only from firmware 3 on
  assign panel_ok  = (state == ST_RUN) && !mb_wr && panel_wr &&
                     (FW_MAJOR >= 3) && (panel_sel < `NACC_IX_COUNT) &&
                     nacc_valid(panel_sel, panel_wdata);
  // vendor bus reaches the address only while switch 4 is off
  assign vb_ok     = (state == ST_RUN) && !mb_wr && !panel_wr && vb_wr &&
                     fitted && !use_modbus &&
                     nacc_valid(`NACC_IX_ADDR, vb_wdata);

  // ****************************************************************
  // next-state logic for sequencer, settings and answers
  // ****************************************************************
  always_comb
  begin
    next_state          = state;
    next_ld_idx         = ld_idx;
    next_cfg            = cfg;
    next_dip_l          = dip_l;
    next_fitted         = fitted;
    next_ready          = ready;
    next_use_modbus     = use_modbus;
    next_mb_address     = modbus_address;
    next_vendor_address = vendor_address;
    next_mb_rdata       = mb_rdata;
    next_mb_ack         = 1'b0;
    next_mb_fault       = 1'b0;
    next_vb_ack         = 1'b0;
    nv_we               = 1'b0;
    nv_waddr            = `NACC_IX_ADDR;
    nv_wdata            = 16'h0000;
    nv_re               = 1'b0;
    nv_raddr            = ld_idx;
    case (state)
      // restore each slot; a blank or corrupt slot keeps its default
      ST_LOAD:
      begin
        nv_re       = (ld_idx < `NACC_IX_COUNT);
        next_ld_idx = ld_idx + 3'h1;
        if (ld_idx != 3'h0)
        begin
          if (nacc_valid(ld_idx - 3'h1, nv_rdata))
          begin
            next_cfg[ld_idx - 3'h1] = nv_rdata;
          end
        end
        if (ld_idx == `NACC_IX_COUNT)
        begin
          next_state = ST_RESOLVE;
        end
      end
      // switches and strap are read once, so a restart is needed
      ST_RESOLVE:
      begin
        next_dip_l      = dip_s;
        next_fitted     = fitted_s;
        next_use_modbus = fitted_s && dip_s[`NACC_DIP_PROTO];
        if (fitted_s)
        begin
          next_vendor_address = {2'b00, dip_s[2:0]} + 5'h01;
        end
        else
        begin
          next_vendor_address = {1'b0, dip_s} + 5'h01;
        end
        // stored address stands in for switch setting 8 only
        if (fitted_s && (dip_s == `NACC_DIP_ALL))
        begin
          next_mb_address = cfg[`NACC_IX_ADDR][7:0];
        end
        else
        begin
          next_mb_address = {5'h00, dip_s[2:0]} + 8'h01;
        end
        next_ready = 1'b1;
        next_state = ST_RUN;
      end
      // serve the three write sources, modbus first
      ST_RUN:
      begin
        if (mb_wr || mb_rd)
        begin
          next_mb_ack   = 1'b1;
          next_mb_fault = !mb_dec[3];
          next_mb_rdata = mb_dec[3] ? cfg[mb_dec[2:0]] : 16'h0000;
        end
        if (mb_ok)
        begin
          next_cfg[mb_dec[2:0]] = mb_wdata;
          nv_we    = (cfg[`NACC_IX_PERSIST] == `NACC_SAVE_YES);
          nv_waddr = mb_dec[2:0];
          nv_wdata = mb_wdata;
          if ((mb_dec[2:0] == `NACC_IX_ADDR) && sw_all_on)
          begin
            next_mb_address = mb_wdata[7:0];
          end
        end
        else if (panel_ok)
        begin
          next_cfg[panel_sel] = panel_wdata;
          nv_we    = 1'b1;
          nv_waddr = panel_sel;
          nv_wdata = panel_wdata;
          if ((panel_sel == `NACC_IX_ADDR) && sw_all_on)
          begin
            next_mb_address = panel_wdata[7:0];
          end
        end
        else if (vb_ok)
        begin
          // settings only, saved if persist is on; the live address moves at a restart with switch setting 8
          next_cfg[`NACC_IX_ADDR] = vb_wdata;
          nv_we       = (cfg[`NACC_IX_PERSIST] == `NACC_SAVE_YES);
          nv_waddr    = `NACC_IX_ADDR;
          nv_wdata    = vb_wdata;
          next_vb_ack = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_LOAD;
      end
    endcase
    // derived flags follow the live settings in the same edge
    next_word_swap = (next_cfg[`NACC_IX_ORDER] == `NACC_ORD_HILO);
    next_persist   = (next_cfg[`NACC_IX_PERSIST] == `NACC_SAVE_YES);
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                   <= ST_LOAD;
      ld_idx                  <= 3'h0;
      cfg[`NACC_IX_ADDR]      <= `NACC_ADDR_RST;
      cfg[`NACC_IX_BAUD]      <= `NACC_BAUD_9600;
      cfg[`NACC_IX_PARITY]    <= `NACC_PAR_NONE;
      cfg[`NACC_IX_PERSIST]   <= `NACC_SAVE_YES;
      cfg[`NACC_IX_ORDER]     <= `NACC_ORD_LOHI;
      dip_l                   <= 4'h0;
      fitted                  <= 1'b0;
      ready                   <= 1'b0;
      use_modbus              <= 1'b0;
      modbus_address          <= 8'h01;
      vendor_address          <= 5'h01;
      mb_rdata                <= 16'h0000;
      mb_ack                  <= 1'b0;
      mb_fault                <= 1'b0;
      vb_ack                  <= 1'b0;
      word_swap               <= 1'b0;
      persist_network         <= 1'b1;
    end
    else
    begin
      state                   <= next_state;
      ld_idx                  <= next_ld_idx;
      cfg                     <= next_cfg;
      dip_l                   <= next_dip_l;
      fitted                  <= next_fitted;
      ready                   <= next_ready;
      use_modbus              <= next_use_modbus;
      modbus_address          <= next_mb_address;
      vendor_address          <= next_vendor_address;
      mb_rdata                <= next_mb_rdata;
      mb_ack                  <= next_mb_ack;
      mb_fault                <= next_mb_fault;
      vb_ack                  <= next_vb_ack;
      word_swap               <= next_word_swap;
      persist_network         <= next_persist;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  assign baud_code   = cfg[`NACC_IX_BAUD];
  assign parity_code = cfg[`NACC_IX_PARITY];

  chk_proto_select:
  assert property (@(posedge clock) disable iff (!rst_n)
    ready |-> (use_modbus == (fitted && dip_l[3])))
    else $error("protocol select does not follow switch 4");
  chk_mb_addr_range:
  assert property (@(posedge clock) disable iff (!rst_n)
    ready |-> (modbus_address >= 8'h01) && (modbus_address <= 8'hF7))
    else $error("modbus address out of range");
  chk_low_switch_wins:
  assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_RESOLVE) && fitted_s && (dip_s != 4'hF) |=>
    (modbus_address == {5'h00, dip_l[2:0]} + 8'h01))
    else $error("switch address did not win");
  chk_vendor_modbus:
  assert property (@(posedge clock) disable iff (!rst_n)
    ready && fitted |-> (vendor_address <= 5'h08) && (vendor_address != 5'h00))
    else $error("vendor address beyond 8 on modbus unit");
  chk_vendor_only:
  assert property (@(posedge clock) disable iff (!rst_n)
    ready && !fitted |-> (vendor_address == {1'b0, dip_l} + 5'h01))
    else $error("vendor address not switches plus one");
  chk_vb_deferred:
  assert property (@(posedge clock) disable iff (!rst_n)
    vb_ok |=> $stable(modbus_address) ##0 vb_ack)
    else $error("vendor write moved live address");
  chk_vb_stored:
  assert property (@(posedge clock) disable iff (!rst_n)
    vb_ok |=> (cfg[0] == $past(vb_wdata)))
    else $error("vendor address write not stored");
  chk_mb_write_now:
  assert property (@(posedge clock) disable iff (!rst_n)
    mb_ok && (mb_addr == 16'h0139) && sw_all_on |=>
    (modbus_address == $past(mb_wdata[7:0])) ##0 mb_ack)
    else $error("modbus address write not immediate");
  chk_bad_ignored:
  assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_RUN) && mb_wr && (mb_addr == 16'h013A) && !mb_ok |=>
    $stable(baud_code))
    else $error("illegal baud code accepted");
  chk_persist_gate:
  assert property (@(posedge clock) disable iff (!rst_n)
    mb_ok |-> (nv_we == persist_network))
    else $error("network save ignores persist setting");
  chk_panel_saved:
  assert property (@(posedge clock) disable iff (!rst_n)
    panel_ok |-> nv_we && (nv_waddr == panel_sel))
    else $error("panel change not saved");
endmodule // nacc_top

// ---- dv/nacc_master_model.sv ----
// modbus master model driving the holding register port of the bank
`timescale 1ns/1ns
module nacc_master_model (
  // clock
  input  wire logic        clock,
  // request side
  output logic             mb_wr,
  output logic             mb_rd,
  output logic      [15:0] mb_addr,
  output logic      [15:0] mb_wdata,
  // answer side
  input  wire logic        mb_ack,
  input  wire logic        mb_fault,
  input  wire logic [15:0] mb_rdata
);
  // idle bus at time zero
  initial
  begin
    mb_wr    = 1'b0;
    mb_rd    = 1'b0;
    mb_addr  = 16'h0000;
    mb_wdata = 16'h0000;
  end

  // one request pulse; the one-cycle answer is taken while it stands,
  // before release; released lines show the inverse, never stale data
  // sole node on the wire, address kept within 1..247
  // the caller moves on to new settings after a change
  task automatic xfer(input logic wr, input logic [15:0] a, d,
                      output logic ack, flt, output logic [15:0] q);
    @(negedge clock);
    mb_wr    = wr;
    mb_rd    = ~wr;
    mb_addr  = a;
    mb_wdata = d;
    @(negedge clock);
    ack      = mb_ack;
    flt      = mb_fault;
    q        = mb_rdata;
    mb_wr    = 1'b0;
    mb_rd    = 1'b0;
    mb_addr  = ~a;
    mb_wdata = ~d;
  endtask
endmodule // nacc_master_model

// ---- dv/nacc_top_tb.sv ----
// self-checking testbench of the node address and settings bank
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
  end
module nacc_top_tb;
  logic        clock, rst_n, modbus_fitted;      // clock, reset, strap
  logic [3:0]  dip_sw;                           // switch pins
  logic        mb_wr, mb_rd, mb_ack, mb_fault;   // modbus port
  logic [15:0] mb_addr, mb_wdata, mb_rdata;      // modbus port data
  logic        vb_wr, vb_ack, panel_wr;          // vendor and panel
  logic [15:0] vb_wdata, panel_wdata;            // their values
  logic [2:0]  panel_sel;                        // panel slot
  logic        ready, use_modbus, word_swap;     // resolved state
  logic        persist_network;                  // persist flag
  logic [7:0]  modbus_address;                   // live node address
  logic [4:0]  vendor_address;                   // vendor node address
  logic [15:0] baud_code, parity_code;           // live codes
  logic        ack, flt;                         // last answer
  logic [15:0] q;                                // last read data
  logic [7:0]  maddr;                            // address snapshot
  int          n_fail, comparisons, cycles, k;   // bookkeeping
  logic [15:0] ofs [5] = '{16'h0139, 16'h013A, 16'h013B, 16'h013D,
                           16'h080A};
  logic [15:0] dfl [5] = '{16'h00F7, 16'h00BC, 16'h003D, 16'h006A,
                           16'h0533};

  // clock, 10 ns period
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  nacc_master_model m (.clock(clock), .mb_wr(mb_wr), .mb_rd(mb_rd),
    .mb_addr(mb_addr), .mb_wdata(mb_wdata), .mb_ack(mb_ack),
    .mb_fault(mb_fault), .mb_rdata(mb_rdata));

  nacc_top #(.FW_MAJOR(3)) dut (.clock(clock), .rst_n(rst_n),
    .dip_sw(dip_sw), .modbus_fitted(modbus_fitted), .mb_wr(mb_wr),
    .mb_rd(mb_rd), .mb_addr(mb_addr), .mb_wdata(mb_wdata),
    .mb_ack(mb_ack), .mb_fault(mb_fault), .mb_rdata(mb_rdata),
    .vb_wr(vb_wr), .vb_wdata(vb_wdata), .vb_ack(vb_ack),
    .panel_wr(panel_wr), .panel_sel(panel_sel),
    .panel_wdata(panel_wdata), .ready(ready), .use_modbus(use_modbus),
    .modbus_address(modbus_address), .vendor_address(vendor_address),
    .baud_code(baud_code), .parity_code(parity_code),
    .word_swap(word_swap), .persist_network(persist_network));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // restart with switches and strap held well before release;
  // p also checks reset state and that early requests get no answer
  task automatic restart(input logic [3:0] d, input logic f, p);
    int i;
    @(negedge clock);
    rst_n = 1'b0;
    dip_sw = d;
    modbus_fitted = f;
    repeat (4) @(negedge clock);
    if (p)
    begin
      `CHK(ready, 1'b0)
      `CHK(persist_network, 1'b1)
    end
    rst_n = 1'b1;
    if (p)
    begin
      m.xfer(1'b0, 16'h013A, 16'h0000, ack, flt, q);
      `CHK(ack, 1'b0)
    end
    i = 0;
    while (ready !== 1'b1 && i < 20)
    begin
      @(negedge clock);
      i++;
    end
    `CHK(ready, 1'b1)
  endtask

  // register write, answered without fault
  task automatic wr(input logic [15:0] a, d);
    m.xfer(1'b1, a, d, ack, flt, q);
    `CHK({ack, flt}, 2'b10)
  endtask

  // register read against an expected image
  task automatic rd(input logic [15:0] a, e);
    m.xfer(1'b0, a, 16'h0000, ack, flt, q);
    `CHK({ack, flt, q}, {2'b10, e})
  endtask

  // vendor bus address request, e is the expected acknowledge
  task automatic vb(input logic [15:0] d, input logic e);
    @(negedge clock);
    vb_wr = 1'b1;
    vb_wdata = d;
    @(negedge clock);
    `CHK(vb_ack, e)
    vb_wr = 1'b0;
    vb_wdata = ~d;
  endtask

  // setup menu write, takes effect on the edge it is taken; one idle cycle follows
  task automatic pn(input logic [2:0] s, input logic [15:0] d);
    @(negedge clock);
    panel_wr = 1'b1;
    panel_sel = s;
    panel_wdata = d;
    @(negedge clock);
    panel_wr = 1'b0;
    panel_wdata = ~d;
    @(negedge clock);
  endtask

  // hang guard, far above the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    {rst_n, modbus_fitted, vb_wr, panel_wr} = 4'h4;
    {dip_sw, panel_sel, vb_wdata, panel_wdata} = 39'h0;
    {n_fail, comparisons, cycles} = '0;
    restart(4'hF, 1'b1, 1'b1);
    for (k = 0; k < 5; k++)
      rd(ofs[k], dfl[k]);
    `CHK(modbus_address, 8'hF7)
    m.xfer(1'b0, 16'h013C, 16'h0000, ack, flt, q);
    `CHK({ack, flt, q}, 18'h30000)
    wr(16'h013A, 16'h00BD);
    `CHK(baud_code, 16'h00BD)
    wr(16'h013A, 16'h1234);
    `CHK(baud_code, 16'h00BD)
    wr(16'h013B, 16'h00BF);
    `CHK(parity_code, 16'h00BF)
    wr(16'h080A, 16'h0532);
    `CHK(word_swap, 1'b1)
    wr(16'h0139, 16'h0020);
    `CHK(modbus_address, 8'h20)
    wr(16'h0139, 16'h0000);
    wr(16'h0139, 16'h00F8);
    `CHK(modbus_address, 8'h20)
    rd(16'h0139, 16'h0020);
    wr(16'h013D, 16'h003B);
    `CHK(persist_network, 1'b0)
    wr(16'h013A, 16'h00BE);
    restart(4'hF, 1'b1, 1'b0);
    `CHK({baud_code, parity_code}, 32'h00BD00BF)
    `CHK({modbus_address, word_swap}, 9'h041)
    // lower switch settings win over the software address
    for (k = 8; k < 15; k++)
    begin
      restart(k[3:0], 1'b1, 1'b0);
      `CHK(use_modbus, 1'b1)
      `CHK(modbus_address, k[7:0] - 8'h07)
      `CHK(vendor_address, k[4:0] - 5'h07)
    end
    wr(16'h0139, 16'h0044);
    `CHK(modbus_address, 8'h07)
    restart(4'h2, 1'b1, 1'b0);
    `CHK({use_modbus, vendor_address}, 6'h03)
    pn(3'h3, 16'h006A);
    `CHK(persist_network, 1'b1)
    pn(3'h2, 16'h00C0);
    `CHK(parity_code, 16'h00C0)
    maddr = modbus_address;
    vb(16'h0030, 1'b1);
    `CHK(modbus_address, maddr)
    vb(16'h0000, 1'b0);
    vb(16'h00F8, 1'b0);
    restart(4'hF, 1'b1, 1'b0);
    `CHK(modbus_address, 8'h30)
    `CHK({parity_code, persist_network}, 17'h00181)
    // vendor-only units: all four switches form the address
    for (k = 0; k < 16; k++)
    begin
      restart(k[3:0], 1'b0, 1'b0);
      `CHK(use_modbus, 1'b0)
      `CHK(vendor_address, k[4:0] + 5'h01)
    end
    tally_and_finish();
  end
endmodule // nacc_top_tb
